// [design/ddsp_map.svh]
// Offsets, field positions, reset values and timing counts of the droop-share PID loop.
// Assumes the master oscillator is CLK; every count below is in its cycles.
`ifndef DDSP_MAP_SVH
`define DDSP_MAP_SVH

`define DDSP_CLK_PERIOD_PS 5000
`define DDSP_SAMPLE_LEAD_PS 13000
`define DDSP_SAMPLE_LEAD_CYC ((`DDSP_SAMPLE_LEAD_PS + `DDSP_CLK_PERIOD_PS - 1) / `DDSP_CLK_PERIOD_PS)
`define DDSP_NPH 6
`define DDSP_CUR_W 8
`define DDSP_ERR_W 6
`define DDSP_REF_W 12
`define DDSP_PWM_PERIOD 200
`define DDSP_FIFO_DEPTH 16
// Reference in steps of 0.78125 mV: 16 steps per select code, 4 per offset step
`define DDSP_REF_BASE 12'h570
`define DDSP_REF_STEP 12'h010
`define DDSP_VSEL_LOW_MAX 6'h14
`define DDSP_VSEL_TOP 6'h3E
`define DDSP_OFS_MAX 5'h10
`define DDSP_DROOP_SH 8
`define DDSP_FILT_SH 4
`define DDSP_PID_SH 8
// Register byte offsets
`define DDSP_REG_CTRL 5'h00
`define DDSP_REG_GAIN 5'h04
`define DDSP_REG_OFS 5'h08
`define DDSP_REG_COEF 5'h0C
`define DDSP_REG_STAT 5'h10
`define DDSP_REG_LOOP 5'h14
// Field positions and reset values
`define DDSP_CTRL_EN_BIT 0
`define DDSP_CTRL_NACT_LSB 1
`define DDSP_NACT_RST 3'h6
`define DDSP_GAIN_RST 8'h10
`define DDSP_STAT_OFF_BIT 6
`define DDSP_STAT_OVR_BIT 7
`define DDSP_STAT_REF_LSB 8

`endif

// [design/ddsp_pkg.sv]
// Types shared by both ends of the droop-share PID loop.
// Assumes nothing beyond the constants header.
package ddsp_pkg;
  // Gray along idle -> data -> idle
  typedef enum logic [0:0] {
    SER_IDLE = 1'b0,
    SER_DATA = 1'b1
  } ddsp_ser_state_type;
endpackage : ddsp_pkg

// [design/ddsp_if.sv]
// Link between one power stage and the controller: serial current and error lines,
// reference code and high/low side commands. One instance per phase.
`timescale 1ns/1ps
`include "ddsp_map.svh"
interface ddsp_if;
  logic cur_line;
  logic err_line;
  logic [`DDSP_REF_W-1:0] ref_code;
  logic hs_cmd;
  logic ls_cmd;
  modport stage (output cur_line, output err_line, input ref_code, input hs_cmd, input ls_cmd);
  modport ctrl (input cur_line, input err_line, output ref_code, output hs_cmd, output ls_cmd);
endinterface : ddsp_if

// [design/ddsp_stage.sv]
// Power stage end: delays the switch commands, samples the current ahead of turn-off,
// serialises current and (feedback stage only) the voltage error.
// Assumes ADC codes arrive synchronous to CLK, which is the master oscillator.
`timescale 1ns/1ps
`include "ddsp_map.svh"

module ddsp_ser_tx #(
  parameter int W = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [W-1:0] DATA,
  input wire logic LOAD,
  output logic BUSY,
  output logic LINE
);
  localparam int CW = $clog2(W + 2);
  logic [W:0] shift_ff;
  logic [CW-1:0] cnt_ff;

  assign BUSY = (cnt_ff != '0);
  assign LINE = shift_ff[W];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      shift_ff <= '0;
      cnt_ff <= '0;
    end else if (LOAD && !BUSY) begin
      shift_ff <= {1'b1, DATA};
      cnt_ff <= CW'(W + 1);
    end else if (BUSY) begin
      shift_ff <= {shift_ff[W-1:0], 1'b0};
      cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule : ddsp_ser_tx

////////////////////////////////////////////////////////////////////////////////

module ddsp_stage #(
  parameter int LEAD = `DDSP_SAMPLE_LEAD_CYC,
  parameter bit FEEDBACK = 1'b0
) (
  input wire logic CLK,
  input wire logic RST_N,
  ddsp_if.stage lnk,
  input wire logic [`DDSP_CUR_W-1:0] ISENSE_CODE,
  input wire logic [`DDSP_REF_W-1:0] VOUT_CODE,
  output logic HS_GATE,
  output logic LS_GATE
);
  import ddsp_pkg::*;

  logic [LEAD:0] hs_dly_ff;
  logic [LEAD:0] ls_dly_ff;
  logic sample_c;
  logic [`DDSP_CUR_W-1:0] sample_ff;
  logic pend_ff;
  logic cur_busy;
  logic signed [`DDSP_ERR_W-1:0] err_ff;
  logic signed [`DDSP_REF_W:0] diff_c;
  logic signed [`DDSP_ERR_W-1:0] nxt_err;

  ////////////////////////////////////////////////////////////////////////////////
  // Gates lag the commands so the falling command edge is seen ahead of turn-off
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      hs_dly_ff <= '0;
      ls_dly_ff <= '0;
    end else begin
      hs_dly_ff <= {hs_dly_ff[LEAD-1:0], lnk.hs_cmd};
      ls_dly_ff <= {ls_dly_ff[LEAD-1:0], lnk.ls_cmd};
    end
  end
  assign HS_GATE = hs_dly_ff[LEAD];
  assign LS_GATE = ls_dly_ff[LEAD];

  // Falling command: gate still on for LEAD more cycles
  assign sample_c = hs_dly_ff[0] && !lnk.hs_cmd;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sample_ff <= '0;
      pend_ff <= 1'b0;
    end else if (sample_c) begin
      sample_ff <= ISENSE_CODE;
      pend_ff <= 1'b1;
    end else if (!cur_busy) begin
      pend_ff <= 1'b0;
    end
  end

  ddsp_ser_tx #(.W(`DDSP_CUR_W)) u_cur_tx (
    .CLK(CLK),
    .RST_N(RST_N),
    .DATA(sample_ff),
    .LOAD(pend_ff),
    .BUSY(cur_busy),
    .LINE(lnk.cur_line)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Error code, saturated to the signed 6-bit range
  always_comb begin
    diff_c = $signed({1'b0, VOUT_CODE}) - $signed({1'b0, lnk.ref_code});
    if (diff_c > 13'sd31) begin
      nxt_err = 6'sd31;
    end else if (diff_c < -13'sd32) begin
      nxt_err = -6'sd32;
    end else begin
      nxt_err = diff_c[`DDSP_ERR_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      err_ff <= '0;
    end else begin
      err_ff <= nxt_err;
    end
  end

  // Only the feedback stage talks on its error line
  ddsp_ser_tx #(.W(`DDSP_ERR_W)) u_err_tx (
    .CLK(CLK),
    .RST_N(RST_N),
    .DATA(err_ff),
    .LOAD(FEEDBACK),
    .BUSY(),
    .LINE(lnk.err_line)
  );
endmodule : ddsp_stage

// [design/ddsp_ctrl.sv]
// Controller end: receives serial currents and error, adds droop and offset, runs PID,
// balances phases and drives a six-phase PWM. Registers over Avalon-MM.
// Assumes phase 0 stage is the feedback stage; all inputs synchronous to CLK.
// Function
// - Current sampled 13 ns before turn-off (code rounds up to 3 CLK cycles, 15 ns at the 5000 ps period)
// - One current sample per switching cycle
// - All timing from one master oscillator
// - Serial current on per-phase line
// - Error is output minus reference, 6 bits
// - PID processes received error number
// - Coefficients loaded from nonvolatile at reset
// - Droop: summed current, gain, filter, add
// - Offset 0 to 50 mV, 3.125 mV steps
// - Programmable load-line slope
// - Average over active phases
// - Filtered per-phase error adjusts level
// - Level compared to ramp sets width
// - Voltage select code sets target
// - Error sent on dedicated line
// - Six-phase PWM drives high and low sides
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "ddsp_map.svh"

module ddsp_ser_rx #(
  parameter int W = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LINE,
  output logic [W-1:0] DATA,
  output logic VALID
);
  import ddsp_pkg::*;
  localparam int CW = $clog2(W + 1);
  ddsp_ser_state_type state_ff;
  logic [CW-1:0] cnt_ff;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_ff <= SER_IDLE;
      cnt_ff <= '0;
      DATA <= '0;
      VALID <= 1'b0;
    end else begin
      VALID <= (state_ff == SER_DATA) && (cnt_ff == CW'(1));
      unique case (state_ff)
        SER_IDLE: begin
          if (LINE) begin
            state_ff <= SER_DATA;
            cnt_ff <= CW'(W);
          end
        end
        SER_DATA: begin
          DATA <= {DATA[W-2:0], LINE};
          cnt_ff <= cnt_ff - 1'b1;
          if (cnt_ff == CW'(1)) begin
            state_ff <= SER_IDLE;
          end
        end
      endcase
    end
  end
endmodule : ddsp_ser_rx

////////////////////////////////////////////////////////////////////////////////

module ddsp_fifo #(
  parameter int W = 6,
  parameter int DEPTH = `DDSP_FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [W-1:0] IN_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [W-1:0] OUT_DATA
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  assign IN_READY = (cnt_ff != (AW+1)'(DEPTH));
  assign OUT_VALID = (cnt_ff != '0);
  assign OUT_DATA = mem_ff[rd_ff];
  assign push = IN_VALID && IN_READY;
  assign pop = OUT_VALID && OUT_READY;

  always_ff @(posedge CLK) begin
    if (push) begin
      mem_ff[wr_ff] <= IN_DATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= wr_ff + AW'(push);
      rd_ff <= rd_ff + AW'(pop);
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ddsp_fifo

////////////////////////////////////////////////////////////////////////////////

module ddsp_ctrl #(
  parameter int NPH = `DDSP_NPH,
  parameter int PERIOD = `DDSP_PWM_PERIOD
) (
  input wire logic CLK,
  input wire logic RST_N,
  ddsp_if.ctrl lnk [NPH],
  input wire logic [5:0] VOLTAGE_SELECT_CODE,
  input wire logic [7:0] NV_PROPORTIONAL_COEFF,
  input wire logic [7:0] NV_INTEGRAL_COEFF,
  input wire logic [7:0] NV_DERIVATIVE_COEFF,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);
  import ddsp_pkg::*;
  localparam int CNTW = $clog2(PERIOD + 1);
  localparam int CW = `DDSP_CUR_W;

  logic [CW-1:0] cur_data [NPH];
  logic [CW-1:0] cur_ff [NPH];
  logic [NPH-1:0] cur_vld;
  logic [`DDSP_ERR_W-1:0] rx_err;
  logic rx_err_vld, fifo_in_rdy, fifo_out_vld;
  logic [`DDSP_ERR_W-1:0] fifo_out;
  logic signed [`DDSP_ERR_W-1:0] err_ff;
  logic en_ff, ovr_ff, ack_ff, tick;
  logic [2:0] nact_ff;
  logic [7:0] gain_ff, proportional_coeff, integral_coeff, derivative_coeff;
  logic [4:0] ofs_ff;
  logic [`DDSP_REF_W-1:0] ref_ff, nxt_ref;
  logic vsel_off;
  logic [CNTW-1:0] ramp_ff, level_ff, phase_comp_level [NPH];
  logic [NPH-1:0] hs_ff, ls_ff;
  logic [18:0] droop_ff, nxt_droop;
  logic signed [23:0] integ_ff, nxt_integ;
  logic signed [15:0] e_prev_ff, e_c;
  logic [10:0] sum_c;
  logic [CW-1:0] average_phase_current;
  logic signed [13:0] ier_f_ff [NPH];
  logic [31:0] rdata_c;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial receivers: one per phase current, one for the error line
  for (genvar g = 0; g < NPH; g++) begin : g_rx
    ddsp_ser_rx #(.W(CW)) u_rx (
      .CLK(CLK),
      .RST_N(RST_N),
      .LINE(lnk[g].cur_line),
      .DATA(cur_data[g]),
      .VALID(cur_vld[g])
    );
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        cur_ff[g] <= '0;
      end else if (cur_vld[g]) begin
        cur_ff[g] <= cur_data[g];
      end
    end
    assign lnk[g].ref_code = ref_ff;
    assign lnk[g].hs_cmd = hs_ff[g];
    assign lnk[g].ls_cmd = ls_ff[g];
  end

  ddsp_ser_rx #(.W(`DDSP_ERR_W)) u_err_rx (
    .CLK(CLK),
    .RST_N(RST_N),
    .LINE(lnk[0].err_line),
    .DATA(rx_err),
    .VALID(rx_err_vld)
  );

  // Drain stalls on the compute cycle so the sample used stays coherent
  ddsp_fifo #(.W(`DDSP_ERR_W), .DEPTH(`DDSP_FIFO_DEPTH)) u_err_fifo (
    .CLK(CLK),
    .RST_N(RST_N),
    .IN_VALID(rx_err_vld),
    .IN_READY(fifo_in_rdy),
    .IN_DATA(rx_err),
    .OUT_VALID(fifo_out_vld),
    .OUT_READY(!tick),
    .OUT_DATA(fifo_out)
  );

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      err_ff <= '0;
    end else if (fifo_out_vld && !tick) begin
      err_ff <= fifo_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pins arrive b5..b0; the table walks in {b4,b3,b2,b1,b0,b5} order
  logic [5:0] vsel_idx;
  assign vsel_idx = {VOLTAGE_SELECT_CODE[4:0], VOLTAGE_SELECT_CODE[5]};
  always_comb begin
    vsel_off = (vsel_idx >= `DDSP_VSEL_TOP);
    if (vsel_idx <= `DDSP_VSEL_LOW_MAX) begin
      nxt_ref = `DDSP_REF_BASE - (`DDSP_REF_STEP * {6'h00, vsel_idx});
    end else if (!vsel_off) begin
      nxt_ref = `DDSP_REF_BASE + (`DDSP_REF_STEP * {6'h00, `DDSP_VSEL_TOP - vsel_idx});
    end else begin
      nxt_ref = '0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ref_ff <= '0;
    end else begin
      ref_ff <= nxt_ref;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Switching-cycle ramp; every loop update happens on its last count
  always_ff @(posedge CLK) begin
    if (!RST_N || ramp_ff == CNTW'(PERIOD - 1)) begin
      ramp_ff <= '0;
    end else begin
      ramp_ff <= ramp_ff + 1'b1;
    end
  end
  assign tick = (ramp_ff == CNTW'(PERIOD - 1));

  always_comb begin
    sum_c = '0;
    for (int p = 0; p < NPH; p++) begin
      if (p < int'(nact_ff)) begin
        sum_c = sum_c + 11'(cur_ff[p]);
      end
    end
    average_phase_current = CW'(sum_c / {8'h00, nact_ff});
  end

  // Droop: gain sets the slope, first-order filter, clamped at the top
  logic [18:0] droop_prod;
  logic signed [20:0] droop_sum;
  always_comb begin
    droop_prod = sum_c * gain_ff;
    droop_sum = $signed({2'b00, droop_ff})
      + (($signed({2'b00, droop_prod}) - $signed({2'b00, droop_ff})) >>> `DDSP_FILT_SH);
    if (droop_sum < 0) begin
      nxt_droop = '0;
    end else if (droop_sum > 21'sh7FFFF) begin
      nxt_droop = 19'h7FFFF;
    end else begin
      nxt_droop = droop_sum[18:0];
    end
  end

  // Error plus droop plus offset, then PID
  logic signed [24:0] p_c, i_c, i_sum;
  logic signed [25:0] d_c;
  logic signed [26:0] u_c, neg_c;
  always_comb begin
    e_c = {{10{err_ff[5]}}, err_ff} + $signed({5'h00, droop_ff[18:`DDSP_DROOP_SH]})
      + $signed({9'h000, ofs_ff, 2'b00});
    p_c = $signed({1'b0, proportional_coeff}) * e_c;
    i_c = $signed({1'b0, integral_coeff}) * e_c;
    d_c = $signed({1'b0, derivative_coeff}) * ($signed({e_c[15], e_c}) - e_prev_ff);
    i_sum = $signed({integ_ff[23], integ_ff}) + i_c;
    if (i_sum[24] != i_sum[23]) begin
      nxt_integ = i_sum[24] ? 24'sh800000 : 24'sh7FFFFF;
    end else begin
      nxt_integ = i_sum[23:0];
    end
    u_c = 27'(p_c) + 27'(integ_ff) + 27'(d_c);
    neg_c = -(u_c >>> `DDSP_PID_SH);
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      droop_ff <= '0;
      integ_ff <= '0;
      e_prev_ff <= '0;
      level_ff <= '0;
    end else if (tick) begin
      droop_ff <= nxt_droop;
      integ_ff <= nxt_integ;
      e_prev_ff <= e_c;
      if (neg_c < 0) begin
        level_ff <= '0;
      end else if (neg_c > PERIOD) begin
        level_ff <= CNTW'(PERIOD);
      end else begin
        level_ff <= CNTW'(neg_c);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-phase balance and PWM, phases spread evenly over the period when all NPH are active
  for (genvar g = 0; g < NPH; g++) begin : g_ph
    logic signed [11:0] ier_c, lvl_c;
    logic [CNTW:0] ramp_c;
    always_comb begin
      ier_c = $signed({4'h0, cur_ff[g]}) - $signed({4'h0, average_phase_current});
      lvl_c = 12'($signed(14'(level_ff)) - (ier_f_ff[g] >>> `DDSP_FILT_SH));
      ramp_c = (CNTW+1)'(ramp_ff) + (CNTW+1)'(g * PERIOD / NPH);
      if (ramp_c >= (CNTW+1)'(PERIOD)) begin
        ramp_c = ramp_c - (CNTW+1)'(PERIOD);
      end
    end
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        ier_f_ff[g] <= '0;
        phase_comp_level[g] <= '0;
      end else if (tick) begin
        ier_f_ff[g] <= ier_f_ff[g] + (((ier_c <<< `DDSP_FILT_SH) - ier_f_ff[g]) >>> 2);
        phase_comp_level[g] <= (lvl_c < 0) ? '0
          : (lvl_c > PERIOD) ? CNTW'(PERIOD) : CNTW'(lvl_c);
      end
    end
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        hs_ff[g] <= 1'b0;
        ls_ff[g] <= 1'b0;
      end else begin
        hs_ff[g] <= en_ff && !vsel_off && (g < int'(nact_ff))
          && (ramp_c[CNTW-1:0] < phase_comp_level[g]);
        ls_ff[g] <= en_ff && !vsel_off && (g < int'(nact_ff))
          && !(ramp_c[CNTW-1:0] < phase_comp_level[g]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, read data registered
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_ff;

  always_comb begin
    unique case (AVS_ADDRESS)
      `DDSP_REG_CTRL: rdata_c = {28'h0000000, nact_ff, en_ff};
      `DDSP_REG_GAIN: rdata_c = {24'h000000, gain_ff};
      `DDSP_REG_OFS: rdata_c = {27'h0000000, ofs_ff};
      `DDSP_REG_COEF: rdata_c = {8'h00, derivative_coeff, integral_coeff, proportional_coeff};
      `DDSP_REG_STAT: rdata_c = {12'h000, ref_ff, ovr_ff, vsel_off, err_ff};
      `DDSP_REG_LOOP: rdata_c = {16'h0000, 8'(level_ff), average_phase_current};
      default: rdata_c = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_ff <= 1'b0;
      AVS_READDATA <= '0;
    end else begin
      ack_ff <= (AVS_READ || AVS_WRITE) && !ack_ff;
      if (AVS_READ && !ack_ff) begin
        AVS_READDATA <= rdata_c;
      end
    end
  end

  // Coefficients copied from nonvolatile store while reset is held
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      proportional_coeff <= NV_PROPORTIONAL_COEFF;
      integral_coeff <= NV_INTEGRAL_COEFF;
      derivative_coeff <= NV_DERIVATIVE_COEFF;
    end else if (AVS_WRITE && ack_ff && AVS_ADDRESS == `DDSP_REG_COEF) begin
      proportional_coeff <= AVS_WRITEDATA[7:0];
      integral_coeff <= AVS_WRITEDATA[15:8];
      derivative_coeff <= AVS_WRITEDATA[23:16];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      en_ff <= 1'b0;
      nact_ff <= `DDSP_NACT_RST;
      gain_ff <= `DDSP_GAIN_RST;
      ofs_ff <= '0;
    end else if (AVS_WRITE && ack_ff) begin
      if (AVS_ADDRESS == `DDSP_REG_CTRL) begin
        en_ff <= AVS_WRITEDATA[`DDSP_CTRL_EN_BIT];
        // Zero or too many phases would break the average
        nact_ff <= (AVS_WRITEDATA[3:1] == 3'h0 || int'(AVS_WRITEDATA[3:1]) > NPH)
          ? 3'(NPH) : AVS_WRITEDATA[3:1];
      end
      if (AVS_ADDRESS == `DDSP_REG_GAIN) begin
        gain_ff <= AVS_WRITEDATA[7:0];
      end
      if (AVS_ADDRESS == `DDSP_REG_OFS) begin
        ofs_ff <= (AVS_WRITEDATA[4:0] > `DDSP_OFS_MAX) ? `DDSP_OFS_MAX : AVS_WRITEDATA[4:0];
      end
    end
  end

  // Sticky overrun: an error word lost to a full buffer; a new loss beats the clear
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ovr_ff <= 1'b0;
    end else if (rx_err_vld && !fifo_in_rdy) begin
      ovr_ff <= 1'b1;
    end else if (AVS_WRITE && ack_ff && AVS_ADDRESS == `DDSP_REG_STAT
      && AVS_WRITEDATA[`DDSP_STAT_OVR_BIT]) begin
      ovr_ff <= 1'b0;
    end
  end
endmodule : ddsp_ctrl

// [test/ddsp_loop_assertions.sv]
// Checker for one stage-to-controller link of the droop-share loop.
// Assumes the serial framing of one start bit then data bits, one bit per CLK.
`timescale 1ns/1ps
`include "ddsp_map.svh"
module ddsp_loop_assertions (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic cur_line,
  input wire logic err_line,
  input wire logic [`DDSP_REF_W-1:0] ref_code,
  input wire logic hs_cmd,
  input wire logic ls_cmd,
  input wire logic HS_GATE,
  input wire logic LS_GATE
);
  logic [3:0] cur_pos_ff;
  logic [2:0] err_pos_ff;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////////
  // Bit position in a frame, 0 while idle
  always_ff @(posedge CLK) begin
    if (!RST_N || cur_pos_ff == 4'h9) cur_pos_ff <= 4'h0;
    else if (cur_pos_ff != 4'h0 || cur_line) cur_pos_ff <= cur_pos_ff + 4'h1;
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) err_pos_ff <= 3'h0;
    else if (err_pos_ff != 3'h0 || err_line) err_pos_ff <= err_pos_ff + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_gate_lead: assert property ($fell(hs_cmd) |-> ##4 $fell(HS_GATE))
    else $error("high-side gate fall not four cycles after command");
  a_low_gate_lead: assert property ($rose(ls_cmd) |-> ##4 $rose(LS_GATE))
    else $error("low-side gate rise not four cycles after command");
  a_cur_start: assert property ($fell(hs_cmd) |-> ##[1:4] (cur_line && cur_pos_ff == 4'h0))
    else $error("no current frame after high-side turn-off");
  a_cur_gap: assert property (cur_pos_ff == 4'h9 |-> !cur_line)
    else $error("current line not idle after nine bits");
  a_err_gap: assert property (err_pos_ff == 3'h7 |-> !err_line)
    else $error("error line not idle after seven bits");
  a_err_cadence: assert property (err_pos_ff == 3'h7 |=> err_line)
    else $error("error frames not every eight cycles");
  a_cmd_exclusive: assert property (!(hs_cmd && ls_cmd))
    else $error("high and low side commanded together");
  a_ref_legal: assert property (ref_code == 12'h000 || (ref_code[3:0] == 4'h0 &&
    ref_code >= 12'h430 && ref_code <= 12'h800))
    else $error("reference outside the select table");
endmodule : ddsp_loop_assertions

// [test/digital_droop_share_pid_loop_test.sv]
// Bench: six stages facing one controller, registers over Avalon-MM.
// Assumes 200 MHz CLK; PWM period shortened to 40 cycles to keep runs short.
`timescale 1ns/1ps
`include "ddsp_map.svh"
module digital_droop_share_pid_loop_test;
  localparam int PER = 40;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [5:0] vsel, hs_gate, ls_gate;
  logic [7:0] nv_p, nv_i, nv_d;
  logic [7:0] isense [6];
  logic [11:0] vout;
  logic [31:0] avs_writedata, avs_readdata, rdata, st;
  int miscompares, compares;
  ddsp_if link [6] ();
  ////////////////////////////////////////////////////////////////////////////////
  ddsp_ctrl #(.NPH(6), .PERIOD(PER)) i_ddsp_ctrl (.CLK(clk), .RST_N(rst_n), .lnk(link),
    .VOLTAGE_SELECT_CODE(vsel), .NV_PROPORTIONAL_COEFF(nv_p), .NV_INTEGRAL_COEFF(nv_i),
    .NV_DERIVATIVE_COEFF(nv_d), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest));
  for (genvar g = 0; g < 6; g++) begin : g_stage
    ddsp_stage #(.LEAD(3), .FEEDBACK(g == 0)) i_ddsp_stage (.CLK(clk), .RST_N(rst_n),
      .lnk(link[g]), .ISENSE_CODE(isense[g]), .VOUT_CODE(vout), .HS_GATE(hs_gate[g]),
      .LS_GATE(ls_gate[g]));
  end
  ddsp_loop_assertions i_ddsp_loop_assertions (.CLK(clk), .RST_N(rst_n),
    .cur_line(link[0].cur_line), .err_line(link[0].err_line), .ref_code(link[0].ref_code),
    .hs_cmd(link[0].hs_cmd), .ls_cmd(link[0].ls_cmd), .HS_GATE(hs_gate[0]),
    .LS_GATE(ls_gate[0]));
  ////////////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction : rnd
  function automatic logic [11:0] exp_ref(input logic [5:0] c);
    logic [5:0] i;
    i = {c[4:0], c[5]};
    if (i <= `DDSP_VSEL_LOW_MAX) return `DDSP_REF_BASE - `DDSP_REF_STEP * i;
    return `DDSP_REF_BASE + `DDSP_REF_STEP * (`DDSP_VSEL_TOP - i);
  endfunction : exp_ref
  function automatic logic [5:0] sat6(input int d);
    if (d > 31) return 6'h1F;
    if (d < -32) return 6'h20;
    return 6'(d);
  endfunction : sat6
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  // Extra edge after release so back-to-back calls never reassign in one step
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk iff avs_waitrequest === 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    logic [4:0] ofs [4];
    logic [2:0] na [4];
    ofs = '{5'h1F, 5'h11, 5'h10, 5'h03};
    na = '{3'h0, 3'h7, 3'h1, 3'h6};
    bus(1'b0, `DDSP_REG_COEF, 32'h0);
    chk(rdata, {8'h00, nv_d, nv_i, nv_p});
    bus(1'b0, `DDSP_REG_GAIN, 32'h0);
    chk(rdata, 32'h10);
    bus(1'b0, `DDSP_REG_CTRL, 32'h0);
    chk(rdata, 32'hC);
    bus(1'b0, 5'h1C, 32'h0);
    chk(rdata, 32'h0);
    foreach (ofs[k]) begin
      bus(1'b1, `DDSP_REG_OFS, {27'h0, ofs[k]});
      bus(1'b0, `DDSP_REG_OFS, 32'h0);
      chk(rdata, (ofs[k] > 5'h10) ? 32'h10 : {27'h0, ofs[k]});
    end
    foreach (na[k]) begin
      bus(1'b1, `DDSP_REG_CTRL, {28'h0, na[k], 1'b0});
      bus(1'b0, `DDSP_REG_CTRL, 32'h0);
      chk(rdata, {28'h0, (na[k] == 3'h0 || na[k] > 3'h6) ? 3'h6 : na[k], 1'b0});
    end
    void'(rnd());
    bus(1'b1, `DDSP_REG_GAIN, {24'h0, st[7:0]});
    bus(1'b0, `DDSP_REG_GAIN, 32'h0);
    chk(rdata, {24'h0, st[7:0]});
    bus(1'b1, `DDSP_REG_STAT, 32'h80);
    bus(1'b0, `DDSP_REG_STAT, 32'h0);
    chk(rdata[7], 1'b0);
    $display("register test done");
  endtask : test_regs
  task automatic test_select();
    logic [5:0] codes [7];
    logic [5:0] c;
    codes = '{6'h00, 6'h0A, 6'h2A, 6'h23, 6'h3E, 6'h1F, 6'h3F};
    for (int k = 0; k < 11; k++) begin
      void'(rnd());
      c = (k < 7) ? codes[k] : st[5:0];
      vsel <= c;
      repeat (4) @(posedge clk);
      bus(1'b0, `DDSP_REG_STAT, 32'h0);
      chk(rdata[6], {c[4:0], c[5]} >= 6'h3E);
      if ({c[4:0], c[5]} < 6'h3E) begin
        chk(rdata[19:8], exp_ref(c));
        if (c == 6'h23) chk(rdata[19:8], 12'h500);
        chk(link[0].ref_code, exp_ref(c));
      end
    end
    $display("select test done");
  endtask : test_select
  task automatic test_error();
    int dl [6];
    int d;
    dl = '{-40, -32, -1, 0, 31, 40};
    vsel <= 6'h23;
    bus(1'b1, `DDSP_REG_CTRL, 32'hD);
    // Slow loop: pulse edges move a step at a time, one current frame each
    bus(1'b1, `DDSP_REG_COEF, 32'h101);
    bus(1'b0, `DDSP_REG_COEF, 32'h0);
    chk(rdata, 32'h101);
    for (int k = 0; k < 9; k++) begin
      void'(rnd());
      d = (k < 6) ? dl[k] : int'(st[5:0]) - 32;
      vout <= exp_ref(6'h23) + 12'(d);
      repeat (3 * PER) @(posedge clk);
      bus(1'b0, `DDSP_REG_STAT, 32'h0);
      chk(rdata[5:0], sat6(d));
    end
    $display("error test done");
  endtask : test_error
  task automatic test_balance();
    logic [2:0] na [2];
    int sum;
    na = '{3'h6, 3'h3};
    // Mid-run reset clears the integrator left by the error test
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, `DDSP_REG_GAIN, 32'h0);
    chk(rdata, `DDSP_GAIN_RST);
    bus(1'b1, `DDSP_REG_GAIN, 32'h0);
    bus(1'b1, `DDSP_REG_COEF, 32'hFF);
    vout <= exp_ref(6'h23) - 12'h004;
    foreach (isense[g]) begin
      void'(rnd());
      isense[g] <= 8'h40 + {2'b00, st[5:0]};
    end
    foreach (na[k]) begin
      bus(1'b1, `DDSP_REG_CTRL, {28'h0, na[k], 1'b1});
      sum = 0;
      for (int g = 0; g < na[k]; g++) sum += isense[g];
      repeat (6 * PER) @(posedge clk);
      bus(1'b0, `DDSP_REG_LOOP, 32'h0);
      chk(rdata[7:0], 8'(sum / na[k]));
    end
    $display("balance test done");
  endtask : test_balance
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    st = 32'd93513;
    miscompares = 0;
    compares = 0;
    rst_n = 1'b0;
    vsel = 6'h23;
    vout = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    void'(rnd());
    nv_p = st[7:0];
    nv_i = st[15:8];
    nv_d = st[23:16];
    foreach (isense[g]) isense[g] = 8'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_regs();
    test_select();
    test_error();
    test_balance();
    report_and_stop();
  end
  // Runs need about 1800 cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule : digital_droop_share_pid_loop_test
